// ### core/snc_sequencer.sv
/*
 Serial NAND command sequencer: framing, opcode decode, cache, busy timing.
 Assumes the link pins are asynchronous to sys_clk and at least eight times slower.
*/
// Behaviour
// (RL1) Host programs pages in ascending order.
// (RL2) Host reads: page load, poll, cache read.
// (RL3) Page load: 24-bit address, 15-bit row, busy.
// (RL4) Host waits for ready before cache read.
// (RL5) Cache read: 8 dummy plus 12-bit column.
// (RL6) No wrap past cache end; output floats.
// (RL7) Release lines edge after last byte.
// (RL8) Host programs: enable, load, execute, poll.
// (RL9) Program sequence ignored without write latch.
// (RL10) Cache load writes bytes from column.
// (RL11) Host keeps at most four partial programs.
// (RL12) Bytes beyond 2112 are discarded.
// (RL13) Execute: 15-bit row, busy program time.
// (RL14) Random load keeps other cache bytes.
// (RL15) Host move: load, enable, execute.
// (RL16) Host enables writes after move load.
// (RL17) Erase: 24-bit address, 15-bit row.
// (RL18) Erase sequence ignored without write latch.
// (RL19) Erase runs alone, busy erase time.
// (RL20) Identification gives five bytes in order.
// (RL21) Pause starts and ends with clock low.
// (RL22) Paused: outputs float, inputs ignored.
// (RL23) Self reset after power-up delay.
// (RL24) Enable sets latch, disable clears it.
// (RL25) Status bit 0 shows busy.
// (RL26) Frames by select, most significant first.
`timescale 1ns/1ps
module snc_sequencer
   import snc_pkg::*;
#(
   parameter int T_RD_US = 50,
   parameter int T_PROG_US = 200,
   parameter int T_BERS_US = 2000,
   parameter int T_RST_US = 100,
   parameter logic [7:0] ID_MAKER = 8'h5a, // Arbitrary value.
   parameter logic [7:0] ID_DEV = 8'ha5, // Arbitrary value.
   parameter logic [7:0] ID_CONT = 8'h3c // Arbitrary value.
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Link pins
   input wire logic cs_n,
   input wire logic sck,
   input wire logic hold_n,
   input wire logic [3:0] sio_in,
   output logic [3:0] sio_out,
   output logic [3:0] sio_oe,
   // Array side
   output logic arr_start,
   output snc_kind_t arr_kind,
   output logic [14:0] arr_row,
   output logic op_in_progress_flag
);
   localparam int RD_CYC = T_RD_US * CLK_MHZ;
   localparam int PROG_CYC = T_PROG_US * CLK_MHZ;
   localparam int BERS_CYC = T_BERS_US * CLK_MHZ;
   localparam int RST_CYC = T_RST_US * CLK_MHZ;

   logic [2:0] cs_sy, sck_sy, hold_sy;
   logic [3:0] io_m, io_s;
   logic pause, sel, act_r, act_f;
   snc_state_t st;
   logic [7:0] op;
   logic [23:0] sh;
   logic [4:0] cnt;
   logic [2:0] bcnt, lanes, idx;
   logic [7:0] osr, ibyte;
   logic [11:0] col;
   logic [3:0] drv;
   logic fin, write_latch_flag;
   logic [31:0] busy_cnt;
   logic [7:0] cache [0:2111];
   logic [19:0] fent [0:1];
   logic [1:0] fcnt;
   logic fwp, frp;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cs_sy <= 3'h7;
         sck_sy <= 3'h0;
         hold_sy <= 3'h7;
         io_m <= 4'h0;
         io_s <= 4'h0;
      end else begin
         cs_sy <= {cs_sy[1:0], cs_n};
         sck_sy <= {sck_sy[1:0], sck};
         hold_sy <= {hold_sy[1:0], hold_n};
         io_m <= sio_in;
         io_s <= io_m;
      end
   end

   assign sel = !cs_sy[1];
   assign act_r = sel && !pause && sck_sy[1] && !sck_sy[2];
   assign act_f = sel && !pause && !sck_sy[1] && sck_sy[2];

   // Pause changes state only while the clock is low, which also covers a change during high.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pause <= 1'b0;
      end else if (!sck_sy[1]) begin
         pause <= !hold_sy[1]; // RL21
      end
   end

   logic [7:0] oc;
   logic [23:0] a;
   logic [4:0] alen;
   logic cmd_done, addr_done, is_cread, is_load, busy;
   logic ev_prog, ev_ers, ev_rd;
   assign oc = {sh[6:0], io_s[0]};
   assign a = {sh[22:0], io_s[0]}; // RL26
   assign busy = busy_cnt != 32'h0;
   assign op_in_progress_flag = busy;
   assign is_cread = op inside {OP_RD1, OP_RDF, OP_RD2, OP_RD4};
   assign is_load = op inside {OP_LD1, OP_LD4, OP_RLD1, OP_RLD4};
   assign alen = (op == OP_GETF || op == OP_RDID) ? ALEN_FEAT :
                 (is_cread || is_load) ? ALEN_COL : ALEN_ROW;
   assign cmd_done = act_r && st == ST_CMD && cnt == 5'h07;
   assign addr_done = act_r && st == ST_ADDR && cnt == alen - 5'h01;
   assign ev_rd = addr_done && op == OP_PRD; // RL3
   assign ev_prog = addr_done && op == OP_PEXE && write_latch_flag; // RL9 RL13
   assign ev_ers = addr_done && op == OP_ERS && write_latch_flag; // RL18 RL17

   logic [7:0] src, cur;
   always_comb begin
      src = 8'h00;
      if (op == OP_GETF) begin
         src = {6'h00, write_latch_flag, busy}; // RL25
      end else if (op == OP_RDID) begin
         src = (idx == 3'h0) ? ID_MAKER : (idx == 3'h1) ? ID_DEV : ID_CONT; // RL20
      end else if (col < CACHE_BYTES[11:0]) begin
         src = cache[col];
      end
   end
   assign cur = (bcnt == 3'h0) ? src : osr;

   logic [7:0] nbyte;
   logic push, byte_in;
   assign nbyte = (lanes == 3'h4) ? {ibyte[3:0], io_s} : {ibyte[6:0], io_s[0]};
   assign byte_in = act_r && st == ST_DIN && bcnt + lanes == 4'h8;
   assign push = byte_in && col < CACHE_BYTES[11:0] && fcnt != 2'h2; // RL12

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= ST_CMD;
         op <= 8'h00;
         sh <= 24'h0;
         cnt <= 5'h0;
         bcnt <= 3'h0;
         lanes <= 3'h1;
         idx <= 3'h0;
         osr <= 8'h00;
         ibyte <= 8'h00;
         col <= 12'h0;
         drv <= 4'h0;
         fin <= 1'b0;
         sio_out <= 4'h0;
      end else if (!sel) begin
         st <= ST_CMD; // RL26
         cnt <= 5'h0;
         drv <= 4'h0;
         fin <= 1'b0;
      end else if (act_r) begin
         sh <= a;
         cnt <= cnt + 5'h01;
         case (st)
            ST_CMD: begin
               if (cmd_done) begin
                  op <= oc;
                  cnt <= 5'h0;
                  lanes <= (oc == OP_RD2) ? 3'h2 :
                           (oc inside {OP_RD4, OP_LD4, OP_RLD4}) ? 3'h4 : 3'h1;
                  if (busy && oc != OP_GETF) begin
                     st <= ST_IGN;
                  end else if (oc inside {OP_WREN, OP_WRDI, OP_RST}) begin
                     st <= ST_IGN;
                  end else begin
                     st <= ST_ADDR;
                  end
               end
            end
            ST_ADDR: begin
               if (addr_done) begin
                  cnt <= 5'h0;
                  bcnt <= 3'h0;
                  idx <= 3'h0;
                  col <= a[11:0]; // RL5 RL10
                  if (op == OP_GETF || (op == OP_RDID && a[7:0] == 8'h00)) begin
                     st <= ST_DOUT;
                  end else if (is_cread) begin
                     st <= ST_DUMMY;
                  end else if (is_load && write_latch_flag) begin
                     st <= ST_DIN; // RL9 RL14
                  end else begin
                     st <= ST_IGN;
                  end
               end
            end
            ST_DUMMY: begin
               if (cnt == DUMMY_CLK - 5'h01) begin
                  st <= ST_DOUT;
               end
            end
            ST_DIN: begin
               ibyte <= nbyte;
               bcnt <= bcnt + lanes;
               if (byte_in && col < CACHE_BYTES[11:0]) begin
                  col <= col + 12'h001;
               end
            end
            ST_DOUT: begin
               if (fin) begin
                  drv <= 4'h0; // RL7
               end
            end
            default: begin
            end
         endcase
      end else if (act_f && st == ST_DOUT) begin
         if (is_cread && bcnt == 3'h0 && col >= CACHE_BYTES[11:0]) begin
            drv <= 4'h0; // RL6
         end else begin
            case (lanes)
               3'h2: begin
                  sio_out <= {2'b00, cur[7:6]};
                  drv <= 4'h3;
               end
               3'h4: begin
                  sio_out <= cur[7:4];
                  drv <= 4'hf;
               end
               default: begin
                  sio_out <= {2'b00, cur[7], 1'b0};
                  drv <= 4'h2;
               end
            endcase
            osr <= cur << lanes;
            bcnt <= bcnt + lanes;
            if (bcnt + lanes == 4'h8) begin
               if (is_cread) begin
                  col <= col + 12'h001;
                  fin <= col == CACHE_BYTES[11:0] - 12'h001;
               end
               if (op == OP_RDID && idx != ID_LAST) begin
                  idx <= idx + 3'h1;
               end
            end
         end
      end
   end

   assign sio_oe = drv & ~{4{pause}}; // RL22

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         write_latch_flag <= 1'b0;
      end else if (cmd_done && !busy && (oc == OP_WRDI || oc == OP_RST)) begin
         write_latch_flag <= 1'b0;
      end else if (cmd_done && !busy && oc == OP_WREN) begin
         write_latch_flag <= 1'b1; // RL24
      end else if (ev_prog || ev_ers) begin
         write_latch_flag <= 1'b0;
      end
   end

   // Busy runs from reset to model the power-up self reset.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_cnt <= 32'(POR_CYC); // RL23
         arr_start <= 1'b0;
         arr_kind <= AK_READ;
         arr_row <= 15'h0;
      end else begin
         arr_start <= ev_rd || ev_prog || ev_ers;
         if (ev_rd || ev_prog || ev_ers) begin
            arr_row <= a[14:0]; // RL3 RL13 RL17
            arr_kind <= ev_rd ? AK_READ : ev_prog ? AK_PROG : AK_ERASE;
         end
         if (busy) begin
            busy_cnt <= busy_cnt - 32'h1;
         end else if (ev_rd) begin
            busy_cnt <= 32'(RD_CYC);
         end else if (ev_prog) begin
            busy_cnt <= 32'(PROG_CYC);
         end else if (ev_ers) begin
            busy_cnt <= 32'(BERS_CYC); // RL19
         end else if (cmd_done && oc == OP_RST) begin
            busy_cnt <= 32'(RST_CYC);
         end
      end
   end

   // Cache writes wait while the array owns the cache; the buffer rides that out.
   logic pop;
   assign pop = fcnt != 2'h0 && !busy;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         fcnt <= 2'h0;
         fwp <= 1'b0;
         frp <= 1'b0;
      end else begin
         fcnt <= fcnt + {1'b0, push} - {1'b0, pop};
         fwp <= fwp ^ push;
         frp <= frp ^ pop;
      end
   end
   always_ff @(posedge sys_clk) begin
      if (push) begin
         fent[fwp] <= {col, nbyte};
      end
      if (pop) begin
         cache[fent[frp][19:8]] <= fent[frp][7:0]; // RL10 RL14
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   a_wren_sets_latch: assert property (cmd_done && oc == OP_WREN && !busy |=>
      write_latch_flag) else $error("write enable did not set latch"); // RL24
   a_prog_blocked: assert property (addr_done && op == OP_PEXE && !write_latch_flag |=>
      !arr_start ##1 !busy) else $error("program ran without latch"); // RL9
   a_erase_blocked: assert property (addr_done && op == OP_ERS && !write_latch_flag |=>
      !arr_start) else $error("erase ran without latch"); // RL18
   a_erase_busy: assert property (ev_ers |=> arr_kind == AK_ERASE && busy [*8])
      else $error("erase not busy"); // RL19
   a_row_capture: assert property (ev_rd |=> arr_row == $past(a[14:0]) && arr_start)
      else $error("row not captured"); // RL3
   a_pause_entry: assert property (!hold_sy[1] && !sck_sy[1] |=> pause && sio_oe == 4'h0)
      else $error("pause not entered"); // RL21
   a_end_release: assert property (act_r && st == ST_DOUT && fin |=> drv == 4'h0)
      else $error("lines not released at end"); // RL7
   a_no_wrap: assert property (act_f && st == ST_DOUT && is_cread && bcnt == 3'h0 &&
      col >= CACHE_BYTES[11:0] |=> drv == 4'h0) else $error("cache read wrapped"); // RL6
   a_load_bound: assert property (byte_in && col >= CACHE_BYTES[11:0] |=> fwp == $past(fwp))
      else $error("byte beyond cache stored"); // RL12
   a_frame_end: assert property (!sel |=> st == ST_CMD && drv == 4'h0)
      else $error("frame not ended"); // RL26
   c_page_read: cover property (ev_rd ##[1:40] busy);
   c_program: cover property (ev_prog);
   c_erase: cover property (ev_ers);
   c_ident: cover property (st == ST_DOUT && op == OP_RDID && idx == ID_LAST);
endmodule // snc_sequencer

// ### inc/snc_pkg.sv
/*
 Constants, opcodes and state codes of the serial NAND command sequencer.
 Assumes one sys_clk domain at the rate given by CLK_MHZ.
*/
package snc_pkg;
   localparam int CLK_MHZ = 10;
   localparam int T_POR_US = 250;
   localparam int POR_CYC = T_POR_US * CLK_MHZ;
   localparam int T_HOST_WAIT_US = 1000;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_GETF = 8'h0f;
   localparam logic [7:0] OP_PRD = 8'h13;
   localparam logic [7:0] OP_RD1 = 8'h03;
   localparam logic [7:0] OP_RDF = 8'h0b;
   localparam logic [7:0] OP_RD2 = 8'h3b;
   localparam logic [7:0] OP_RD4 = 8'h6b;
   localparam logic [7:0] OP_LD1 = 8'h02;
   localparam logic [7:0] OP_LD4 = 8'h32;
   localparam logic [7:0] OP_RLD1 = 8'h84;
   localparam logic [7:0] OP_RLD4 = 8'h34;
   localparam logic [7:0] OP_PEXE = 8'h10;
   localparam logic [7:0] OP_ERS = 8'hd8;
   localparam logic [7:0] OP_RDID = 8'h9f;
   localparam logic [7:0] OP_RST = 8'hff;
   localparam logic [12:0] CACHE_BYTES = 13'h840;
   localparam logic [4:0] ALEN_FEAT = 5'h08;
   localparam logic [4:0] ALEN_COL = 5'h10;
   localparam logic [4:0] ALEN_ROW = 5'h18;
   localparam logic [4:0] DUMMY_CLK = 5'h08;
   localparam logic [2:0] ID_LAST = 3'h4;
   typedef enum logic [2:0] {
      ST_CMD = 3'b000,
      ST_ADDR = 3'b001,
      ST_DUMMY = 3'b010,
      ST_DOUT = 3'b011,
      ST_DIN = 3'b100,
      ST_IGN = 3'b101
   } snc_state_t;
   typedef enum logic [1:0] {
      AK_READ = 2'b00,
      AK_PROG = 2'b01,
      AK_ERASE = 2'b10
   } snc_kind_t;
endpackage

// ### tb/snc_host_model.sv
/*
 Host link model: drives select, serial clock, pause and data lines.
 Assumes the bench clock; each serial clock phase lasts four sys_clk cycles.
*/
`timescale 1ns/1ps
module snc_host_model (
   // Clock
   input wire logic sys_clk,
   // Link toward the device
   output logic cs_n,
   output logic sck,
   output logic hold_n,
   output logic [3:0] sio_in,
   input wire logic [3:0] sio_out,
   input wire logic [3:0] sio_oe
);
   logic [3:0] last_oe;

   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      hold_n = 1'b1;
      sio_in = 4'h0;
      last_oe = 4'h0;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // Device output is taken just before the rising edge, where it has settled longest.
   task automatic chunk(input logic [3:0] d, output logic [3:0] q);
      sio_in <= d;
      wt(4);
      // A line that the device does not drive reads inverted, so a missing drive cannot pass.
      q = sio_out ^ ~sio_oe;
      last_oe = sio_oe;
      sck <= 1'b1;
      wt(4);
      sck <= 1'b0;
   endtask

   task automatic xbyte(input int w, input logic [7:0] din, output logic [7:0] dout);
      logic [3:0] q;
      logic [7:0] sh;
      sh = din;
      dout = 8'h00;
      for (int k = 0; k < 8 / w; k++) begin
         chunk((w == 4) ? sh[7:4] : {3'h0, sh[7]}, q);
         dout = (w == 4) ? {dout[3:0], q} : (w == 2) ? {dout[5:0], q[1:0]} : {dout[6:0], q[1]};
         sh = sh << w;
      end
   endtask

   task automatic cmd(input logic [7:0] op, input int nadr, input logic [23:0] adr);
      logic [7:0] b;
      logic [23:0] a;
      a = adr << (8 * (3 - nadr));
      cs_n <= 1'b0;
      wt(4);
      xbyte(1, op, b);
      for (int i = 0; i < nadr; i++) begin
         xbyte(1, a[23:16], b);
         a = a << 8;
      end
   endtask

   // The released data lines are inverted so that a stale value cannot pass as valid.
   task automatic stop();
      wt(4);
      cs_n <= 1'b1;
      sio_in <= ~sio_in;
      wt(8);
   endtask

   // Pause with the clock low, then one clock pulse that the device must ignore.
   task automatic pause(output logic [3:0] oe_seen);
      hold_n <= 1'b0;
      wt(8);
      sck <= 1'b1;
      wt(4);
      oe_seen = sio_oe;
      sck <= 1'b0;
      wt(4);
      hold_n <= 1'b1;
      wt(8);
   endtask
endmodule // snc_host_model

// ### tb/tb_top.sv
/*
 Self-checking bench of the serial NAND command sequencer.
 Assumes the package, the sequencer and the host model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
   import snc_pkg::*;
   localparam logic [7:0] MK = 8'h61; // Arbitrary value.
   localparam logic [7:0] DV = 8'h62; // Arbitrary value.
   localparam logic [7:0] CT = 8'h63; // Arbitrary value.
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic cs_n, sck, hold_n, arr_start, op_in_progress_flag;
   logic [3:0] sio_in, sio_out, sio_oe, q;
   logic [14:0] arr_row;
   logic [7:0] b;
   snc_kind_t arr_kind;
   int n_mismatch = 0;
   int n_compared = 0;
   int n_start = 0;
   int cyc = 0;

   always #50 sys_clk = ~sys_clk;

   snc_host_model host (.sys_clk(sys_clk), .cs_n(cs_n), .sck(sck), .hold_n(hold_n),
      .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe));
   snc_sequencer #(.T_RD_US(1), .T_PROG_US(1), .T_BERS_US(40), .T_RST_US(1),
      .ID_MAKER(MK), .ID_DEV(DV), .ID_CONT(CT)) dut (.sys_clk(sys_clk), .arst_n(arst_n),
      .cs_n(cs_n), .sck(sck), .hold_n(hold_n), .sio_in(sio_in), .sio_out(sio_out),
      .sio_oe(sio_oe), .arr_start(arr_start), .arr_kind(arr_kind), .arr_row(arr_row),
      .op_in_progress_flag(op_in_progress_flag));

   task automatic end_sim();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (arr_start === 1'b1) begin
         n_start <= n_start + 1;
      end
      if (cyc == 60000) begin
         n_mismatch = n_mismatch + 1;
         end_sim();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic op1(input logic [7:0] op);
      host.cmd(op, 0, 24'h000000);
      host.stop();
   endtask

   task automatic status(input logic [7:0] exp);
      host.cmd(OP_GETF, 1, 24'h0000c0);
      host.xbyte(1, 8'h00, b);
      host.stop();
      chk("status", b, exp);
   endtask

   task automatic load(input logic [7:0] op, input logic [11:0] col, input int w, input int n,
      input logic [7:0] base);
      host.cmd(op, 2, {8'h00, 4'hf, col});
      for (int i = 0; i < n; i++) begin
         host.xbyte(w, base + 8'(i), b);
      end
      host.stop();
   endtask

   task automatic rd_open(input logic [7:0] op, input logic [11:0] col);
      host.cmd(op, 2, {8'h00, 4'hf, col});
      for (int i = 0; i < DUMMY_CLK; i++) begin
         host.chunk(4'h0, q);
      end
   endtask

   task automatic rd_chk(input int w, input logic [7:0] exp[$]);
      foreach (exp[i]) begin
         host.xbyte(w, 8'h00, b);
         chk("read byte", b, exp[i]);
      end
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 3000 && op_in_progress_flag !== 1'b0; i++) begin
         @(posedge sys_clk);
      end
      chk("busy", op_in_progress_flag, 1'b0);
   endtask

   task automatic t_por();
      int rel;
      rel = cyc;
      status(8'h01);
      op1(OP_WREN);
      while (cyc < rel + 2490) @(posedge sys_clk);
      chk("power-up busy", op_in_progress_flag, 1'b1);
      repeat (20) @(posedge sys_clk);
      chk("power-up ready", op_in_progress_flag, 1'b0);
      status(8'h00);
   endtask

   task automatic t_id();
      host.cmd(OP_RDID, 1, 24'h000000);
      rd_chk(1, '{MK, DV, CT, CT, CT, CT});
      host.stop();
      host.cmd(OP_RDID, 1, 24'h000001);
      host.xbyte(1, 8'h00, b);
      host.stop();
      chk("id refused", host.last_oe, 4'h0);
   endtask

   task automatic t_latch();
      int n0;
      op1(OP_WREN);
      status(8'h02);
      op1(OP_WRDI);
      status(8'h00);
      n0 = n_start;
      load(OP_LD1, 12'h010, 1, 1, 8'h77);
      host.cmd(OP_PEXE, 3, 24'h000005);
      host.stop();
      host.cmd(OP_ERS, 3, 24'h000040);
      host.stop();
      chk("refused start", n_start - n0, 0);
      chk("refused busy", op_in_progress_flag, 1'b0);
   endtask

   task automatic t_cache();
      logic [7:0] ops[4] = '{OP_RD1, OP_RDF, OP_RD2, OP_RD4};
      int ws[4] = '{1, 1, 2, 4};
      op1(OP_WREN);
      load(OP_LD1, 12'h100, 1, 4, 8'ha0);
      load(OP_RLD1, 12'h101, 1, 1, 8'h55);
      load(OP_LD4, 12'h200, 4, 2, 8'hc0);
      load(OP_RLD4, 12'h201, 4, 1, 8'hd1);
      for (int i = 0; i < 4; i++) begin
         rd_open(ops[i], 12'h100);
         rd_chk(ws[i], '{8'ha0, 8'h55, 8'ha2, 8'ha3});
         host.stop();
      end
      rd_open(OP_RD1, 12'h200);
      rd_chk(1, '{8'hc0, 8'hd1});
      host.stop();
   endtask

   task automatic t_end();
      load(OP_RLD1, 12'h000, 1, 1, 8'h11);
      load(OP_LD1, 12'h83e, 1, 4, 8'he0);
      for (int i = 0; i < 2; i++) begin
         rd_open((i == 0) ? OP_RD1 : OP_RD4, 12'h83e);
         rd_chk((i == 0) ? 1 : 4, '{8'he0, 8'he1});
         chk("drive last byte", host.last_oe, (i == 0) ? 4'h2 : 4'hf);
         host.xbyte((i == 0) ? 1 : 4, 8'h00, b);
         chk("drive past end", host.last_oe, 4'h0);
         host.stop();
      end
      rd_open(OP_RD1, 12'h000);
      rd_chk(1, '{8'h11});
      host.stop();
   endtask

   task automatic t_pause();
      rd_open(OP_RD1, 12'h100);
      rd_chk(1, '{8'ha0});
      host.pause(q);
      chk("drive paused", q, 4'h0);
      rd_chk(1, '{8'h55, 8'ha2});
      host.stop();
   endtask

   task automatic t_arr();
      logic [7:0] ops[3] = '{OP_PRD, OP_PEXE, OP_ERS};
      logic [14:0] rows[3] = '{15'h12ab, 15'h0001, 15'h7fff};
      logic [7:0] sts[3] = '{8'h02, 8'h00, 8'h01};
      snc_kind_t kinds[3] = '{AK_READ, AK_PROG, AK_ERASE};
      int n0;
      for (int i = 0; i < 3; i++) begin
         if (i > 0) begin
            op1(OP_WREN);
         end
         n0 = n_start;
         host.cmd(ops[i], 3, {9'h1ff, rows[i]});
         host.stop();
         status(sts[i]);
         wait_idle();
         chk("start count", n_start - n0, 1);
         chk("kind", arr_kind, kinds[i]);
         chk("row", arr_row, rows[i]);
      end
   endtask

   task automatic t_rst();
      op1(OP_WREN);
      host.cmd(OP_RST, 0, 24'h000000);
      chk("reset busy", op_in_progress_flag, 1'b1);
      host.stop();
      status(8'h00);
   endtask

   initial begin
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      t_por();
      t_id();
      t_latch();
      t_cache();
      t_end();
      t_pause();
      t_arr();
      t_rst();
      end_sim();
   end
endmodule // tb_top
